// file: verilog/xfer_pkg.sv
// shared constants and carrier types of the two-channel bus-steal transfer block
// assumes a 32-bit axi4-lite register bus and an 8-bit internal data bus to ram
package xfer_pkg;

   // ****************************************
   // register map (printed offsets are not multiples of four: index * 4 is the byte address)
   // ****************************************
   localparam logic [15:0] IDX_CHAN1_BASE_LOW = 16'h7fe0;
   localparam logic [15:0] IDX_CHAN1_BASE_HIGH = 16'h7fe1;
   localparam logic [15:0] IDX_CHAN2_BASE_LOW = 16'h7fe2;
   localparam logic [15:0] IDX_CHAN2_BASE_HIGH = 16'h7fe3;
   localparam logic [15:0] IDX_CHAN1_COUNT_LOW = 16'h7fe4;
   localparam logic [15:0] IDX_CHAN2_COUNT_LOW = 16'h7fe5;
   localparam logic [15:0] IDX_CHAN1_PROGRESS = 16'h7fe6;
   localparam logic [15:0] IDX_CHAN2_PROGRESS = 16'h7fe7;
   localparam logic [15:0] IDX_SERVICE_TEST = 16'h7ffe;
   localparam logic [15:0] IDX_SERVICE_DISABLE = 16'h7fff;

   // ****************************************
   // reset values and masks
   // ****************************************
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [15:0] BASE_HIGH_MASK = 16'hff00;
   localparam logic [15:0] BASE_LOW_MASK = 16'h00f0;
   localparam logic [11:0] COUNT_HIGH_MASK = 12'h0f00;
   localparam logic [11:0] COUNT_LOW_MASK = 12'h00ff;
   localparam logic [11:0] COUNT_BIAS = 12'h002;
   localparam logic [11:0] BYTE_STEP = 12'h001;
   localparam logic [7:0] DISABLE_MASK = 8'h3f;
   localparam logic [7:0] HIGH_ADDR_MASK = 8'h1f;

   // ****************************************
   // disable-control field positions
   // ****************************************
   localparam int CHAN2_STALL_BLOCK = 5;
   localparam int CHAN2_STEAL_BLOCK = 4;
   localparam int CHAN1_STALL_BLOCK = 3;
   localparam int CHAN1_STEAL_BLOCK = 2;
   localparam int TEST_STALL_BLOCK = 1;
   localparam int TEST_STEAL_BLOCK = 0;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ****************************************
   // carrier types
   // ****************************************
   typedef enum logic [1:0] {DIR_TO_RAM, DIR_FROM_RAM} dir_unused_t;

   typedef struct packed {
      logic steal_req;
      logic stall_req;
      logic to_ram;
      logic [7:0] wdata;
   } mod_req_t;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
   } mod_ack_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ram_req_t;

   typedef enum {ST_IDLE, ST_XFER} xfer_state_t;

endpackage

// file: verilog/bus_steal_xfer.sv
// two-channel transfer controller moving bytes between two serial modules and ram
// assumes a single 200 mhz clock, an axi4-lite master, and a ram that completes in one cycle
`timescale 1ns/10ps

module bus_steal_xfer (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // axi4-lite write address and data
   input wire logic [17:0] S_AWADDR,
   input wire logic S_AWVALID,
   output logic S_AWREADY,
   input wire logic [31:0] S_WDATA,
   input wire logic [3:0] S_WSTRB,
   input wire logic S_WVALID,
   output logic S_WREADY,
   // axi4-lite write response
   output logic [1:0] S_BRESP,
   output logic S_BVALID,
   input wire logic S_BREADY,
   // axi4-lite read
   input wire logic [17:0] S_ARADDR,
   input wire logic S_ARVALID,
   output logic S_ARREADY,
   output logic [31:0] S_RDATA,
   output logic [1:0] S_RRESP,
   output logic S_RVALID,
   input wire logic S_RREADY,
   // serial module one and two
   input xfer_pkg::mod_req_t MOD1_REQ,
   output xfer_pkg::mod_ack_t MOD1_ACK,
   input xfer_pkg::mod_req_t MOD2_REQ,
   output xfer_pkg::mod_ack_t MOD2_ACK,
   // cpu bus arbitration
   input wire logic CPU_BUS_BUSY,
   output logic CPU_HOLD,
   // internal data bus to ram
   output xfer_pkg::ram_req_t RAM_REQ,
   input wire logic [7:0] RAM_RDATA
);
   import xfer_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [1:0][7:0] base_low;
      logic [1:0][7:0] base_high;
      logic [1:0][7:0] count_low;
      logic [1:0][11:0] progress;
      logic [7:0] test;
      logic [7:0] disable_ctl;
      xfer_state_t state;
      logic chan;
      logic hold;
      ram_req_t ram;
      mod_ack_t ack1;
      mod_ack_t ack2;
      logic aw_got;
      logic w_got;
      logic [15:0] aw_idx;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t q, d;

   function automatic logic [15:0] chan_base(input logic [7:0] hi, input logic [7:0] lo);
      chan_base = (({hi, 8'h00}) & BASE_HIGH_MASK) + ({8'h00, lo} & BASE_LOW_MASK);
   endfunction

   function automatic logic [11:0] chan_total(input logic [7:0] lo, input logic [7:0] cnt);
      chan_total = (({lo[3:0], 8'h00}) & COUNT_HIGH_MASK) + ({4'h0, cnt} & COUNT_LOW_MASK)
         + COUNT_BIAS;
   endfunction

   function automatic logic mapped(input logic [15:0] idx);
      mapped = (idx >= IDX_CHAN1_BASE_LOW && idx <= IDX_CHAN2_PROGRESS) ||
         idx == IDX_SERVICE_TEST || idx == IDX_SERVICE_DISABLE;
   endfunction

   logic [1:0] steal_ok;
   logic [1:0] stall_ok;
   logic [1:0] live;
   logic [1:0] want;
   mod_req_t sel_req;
   logic sel;

   // ****************************************
   // request qualification
   // ****************************************
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         // finished channel is idle until reinitialised
         live[c] = q.progress[c] < chan_total(q.base_low[c], q.count_low[c]);
      end
      steal_ok[0] = MOD1_REQ.steal_req && !q.disable_ctl[CHAN1_STEAL_BLOCK];
      stall_ok[0] = MOD1_REQ.stall_req && !q.disable_ctl[CHAN1_STALL_BLOCK];
      steal_ok[1] = MOD2_REQ.steal_req && !q.disable_ctl[CHAN2_STEAL_BLOCK];
      stall_ok[1] = MOD2_REQ.stall_req && !q.disable_ctl[CHAN2_STALL_BLOCK];
      want = (steal_ok | stall_ok) & live;
      sel = !want[0];
      sel_req = sel ? MOD2_REQ : MOD1_REQ;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [15:0] ridx;
      logic [7:0] rv;
      logic [7:0] wb;
      ridx = 16'h0000;
      rv = 8'h00;
      wb = 8'h00;
      d = q;
      d.ram.req = 1'b0;
      d.ack1.ack = 1'b0;
      d.ack2.ack = 1'b0;

      // ---- transfer engine ----
      case (q.state)
         ST_IDLE: begin
            d.hold = 1'b0;
            if (want != 2'b00) begin
               if (stall_ok[sel]) begin
                  // freeze the cpu, then take the bus
                  d.hold = 1'b1;
                  if (q.hold) begin
                     d.state = ST_XFER;
                  end
               end else if (!CPU_BUS_BUSY) begin
                  // only in a cycle the cpu leaves idle
                  d.state = ST_XFER;
               end
               if (d.state == ST_XFER) begin
                  d.chan = sel;
                  d.ram.req = 1'b1;
                  d.ram.we = sel_req.to_ram;
                  d.ram.wdata = sel_req.wdata;
                  d.ram.addr = chan_base(q.base_high[sel], q.base_low[sel]) +
                     {4'h0, q.progress[sel]};
               end
            end
         end
         ST_XFER: begin
            // ram answered this cycle; hand data back and advance
            d.state = ST_IDLE;
            d.hold = 1'b0;
            // byte mode steps by one; word mode is not built
            d.progress[q.chan] = q.progress[q.chan] + BYTE_STEP;
            if (q.chan) begin
               d.ack2.ack = 1'b1;
               d.ack2.rdata = RAM_RDATA;
            end else begin
               d.ack1.ack = 1'b1;
               d.ack1.rdata = RAM_RDATA;
            end
         end
         default: begin
            d.state = ST_IDLE;
            d.hold = 1'b0;
         end
      endcase

      // ---- axi4-lite write ----
      if (S_AWVALID && !q.aw_got && !q.bvalid) begin
         d.aw_got = 1'b1;
         d.aw_idx = S_AWADDR[17:2];
      end
      if (S_WVALID && !q.w_got && !q.bvalid) begin
         d.w_got = 1'b1;
         d.wdata = S_WDATA;
         d.wstrb = S_WSTRB;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = mapped(q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
         wb = q.wdata[7:0];
         if (q.wstrb[0]) begin
            case (q.aw_idx)
               IDX_CHAN1_BASE_LOW: d.base_low[0] = wb;
               IDX_CHAN2_BASE_LOW: d.base_low[1] = wb;
               IDX_CHAN1_BASE_HIGH: d.base_high[0] = wb & HIGH_ADDR_MASK;
               IDX_CHAN2_BASE_HIGH: d.base_high[1] = wb & HIGH_ADDR_MASK;
               IDX_CHAN1_COUNT_LOW: d.count_low[0] = wb;
               IDX_CHAN2_COUNT_LOW: d.count_low[1] = wb;
               IDX_SERVICE_TEST: d.test = wb;
               IDX_SERVICE_DISABLE: d.disable_ctl = wb & DISABLE_MASK;
               default: d.test = d.test;
            endcase
            // rewriting the count-low byte restarts that channel's progress
            if (q.aw_idx == IDX_CHAN1_COUNT_LOW) begin
               d.progress[0] = 12'h000;
            end
            if (q.aw_idx == IDX_CHAN2_COUNT_LOW) begin
               d.progress[1] = 12'h000;
            end
         end
      end
      if (q.bvalid && S_BREADY) begin
         d.bvalid = 1'b0;
      end

      // ---- axi4-lite read ----
      if (S_ARVALID && !q.rvalid) begin
         ridx = S_ARADDR[17:2];
         case (ridx)
            IDX_CHAN1_BASE_LOW: rv = q.base_low[0];
            IDX_CHAN2_BASE_LOW: rv = q.base_low[1];
            IDX_CHAN1_BASE_HIGH: rv = q.base_high[0];
            IDX_CHAN2_BASE_HIGH: rv = q.base_high[1];
            IDX_CHAN1_COUNT_LOW: rv = q.count_low[0];
            IDX_CHAN2_COUNT_LOW: rv = q.count_low[1];
            // progress is read-only, low byte here, high nibble above
            IDX_CHAN1_PROGRESS: rv = q.progress[0][7:0];
            IDX_CHAN2_PROGRESS: rv = q.progress[1][7:0];
            IDX_SERVICE_TEST: rv = q.test;
            IDX_SERVICE_DISABLE: rv = q.disable_ctl;
            default: rv = 8'h00;
         endcase
         d.rvalid = 1'b1;
         d.rresp = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
         d.rdata = {20'h00000, 4'h0, rv};
         if (ridx == IDX_CHAN1_PROGRESS) begin
            d.rdata[11:8] = q.progress[0][11:8];
         end
         if (ridx == IDX_CHAN2_PROGRESS) begin
            d.rdata[11:8] = q.progress[1][11:8];
         end
      end
      if (q.rvalid && S_RREADY) begin
         d.rvalid = 1'b0;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         q <= '0;
         q.state <= ST_IDLE;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign S_AWREADY = !q.aw_got && !q.bvalid;
   assign S_WREADY = !q.w_got && !q.bvalid;
   assign S_BVALID = q.bvalid;
   assign S_BRESP = q.bresp;
   assign S_ARREADY = !q.rvalid;
   assign S_RVALID = q.rvalid;
   assign S_RDATA = q.rdata;
   assign S_RRESP = q.rresp;
   assign CPU_HOLD = q.hold;
   assign RAM_REQ = q.ram;
   assign MOD1_ACK = q.ack1;
   assign MOD2_ACK = q.ack2;

endmodule

// file: dv/bus_steal_xfer_props.sv
// port-level checker of the two-channel transfer block
// assumes it is bound onto bus_steal_xfer from the bench top file
`timescale 1ns/10ps
module bus_steal_xfer_props (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // register read channel
   input wire logic S_ARVALID,
   input wire logic S_ARREADY,
   input wire logic S_RVALID,
   // modules, cpu and ram
   input xfer_pkg::mod_req_t MOD1_REQ,
   input xfer_pkg::mod_ack_t MOD1_ACK,
   input xfer_pkg::mod_req_t MOD2_REQ,
   input xfer_pkg::mod_ack_t MOD2_ACK,
   input wire logic CPU_BUS_BUSY,
   input wire logic CPU_HOLD,
   input xfer_pkg::ram_req_t RAM_REQ
);
   import xfer_pkg::*;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // ****************************************
   // assertions
   // ****************************************
   steal_idle_a: assert property (RAM_REQ.req && !$past(CPU_HOLD) |-> !$past(CPU_BUS_BUSY))
      else $error("steal transfer used a busy cpu cycle");
   ack_after_a: assert property (RAM_REQ.req |=> MOD1_ACK.ack != MOD2_ACK.ack)
      else $error("ram access not followed by exactly one ack");
   hold_seq_a: assert property ($rose(CPU_HOLD) |=> CPU_HOLD && RAM_REQ.req ##1 !CPU_HOLD)
      else $error("cpu hold not wrapped around the ram access");
   hold_cause_a: assert property ($rose(CPU_HOLD) |->
      $past(MOD1_REQ.stall_req || MOD2_REQ.stall_req))
      else $error("cpu held without a stall request");
   xfer_gap_a: assert property (RAM_REQ.req |=> !RAM_REQ.req)
      else $error("transfers overlap");
   dir_one_a: assert property (MOD1_ACK.ack |-> $past(RAM_REQ.we) == $past(MOD1_REQ.to_ram))
      else $error("module one direction wrong");
   dir_two_a: assert property (MOD2_ACK.ack |-> $past(RAM_REQ.we) == $past(MOD2_REQ.to_ram))
      else $error("module two direction wrong");
   read_answer_a: assert property (S_ARVALID && S_ARREADY |=> S_RVALID)
      else $error("register read not answered");
   stall_seen_c: cover property ($rose(CPU_HOLD));
   steal_seen_c: cover property (RAM_REQ.req && !$past(CPU_HOLD));
   both_req_c: cover property (MOD1_REQ.steal_req && MOD2_REQ.steal_req);
endmodule

// file: dv/serial_module_model.sv
// behavioural serial module: one request per start pulse, held until acked
// assumes start is a one-cycle pulse driven just after a rising edge
`timescale 1ns/10ps
module serial_module_model (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // bench command
   input wire logic start,
   input wire logic stall,
   input wire logic [7:0] data,
   // controller side
   input xfer_pkg::mod_ack_t ack,
   output xfer_pkg::mod_req_t req
);
   import xfer_pkg::*;
   logic pend_q;
   logic stall_q;
   logic [7:0] data_q;
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pend_q <= 1'b0;
         stall_q <= 1'b0;
         data_q <= 8'h00;
      end else if (start) begin
         pend_q <= 1'b1;
         stall_q <= stall;
         data_q <= data;
      end else if (ack.ack) begin
         pend_q <= 1'b0;
      end
   end
   // withdrawn in the ack cycle so one request is never served twice
   assign req.steal_req = pend_q && !stall_q && !ack.ack;
   assign req.stall_req = pend_q && stall_q && !ack.ack;
   // released lines show the inverse of the last value, never a stale copy
   assign req.to_ram = pend_q ? data_q[7] : !data_q[7];
   assign req.wdata = pend_q ? data_q : ~data_q;
endmodule

// file: dv/test_two_channel_bus_steal_transfer.sv
// self-checking bench of the two-channel transfer block with module and ram models
// assumes the package, design, checker and module model are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module test_two_channel_bus_steal_transfer;
   import xfer_pkg::*;
   logic CLK_SYS = 1'b0, RST = 1'b1, CPU_BUS_BUSY = 1'b0, lw = 1'b0;
   logic S_AWVALID = 1'b0, S_WVALID = 1'b0, S_BREADY = 1'b0, S_ARVALID = 1'b0, S_RREADY = 1'b0;
   logic S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, CPU_HOLD;
   logic [17:0] S_AWADDR = '0, S_ARADDR = '0;
   logic [31:0] S_WDATA = '0, S_RDATA;
   logic [1:0] S_BRESP, S_RRESP, brsp;
   logic [15:0] la = '0, e;
   logic [7:0] RAM_RDATA, dat[2] = '{8'h00, 8'h00};
   logic go[2] = '{1'b0, 1'b0}, st[2] = '{1'b0, 1'b0};
   mod_req_t req[2];
   mod_ack_t ack[2];
   ram_req_t RAM_REQ;
   int base[2], tot[2], prog[2], nack[2], ord[$], n, cyc = 0, n_fail = 0, comparisons = 0;
   bus_steal_xfer bus_steal_xfer_inst (.CLK_SYS(CLK_SYS), .RST(RST),
      .S_AWADDR(S_AWADDR), .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY), .S_WDATA(S_WDATA),
      .S_WSTRB(4'h1), .S_WVALID(S_WVALID), .S_WREADY(S_WREADY), .S_BRESP(S_BRESP),
      .S_BVALID(S_BVALID), .S_BREADY(S_BREADY), .S_ARADDR(S_ARADDR), .S_ARVALID(S_ARVALID),
      .S_ARREADY(S_ARREADY), .S_RDATA(S_RDATA), .S_RRESP(S_RRESP), .S_RVALID(S_RVALID),
      .S_RREADY(S_RREADY), .MOD1_REQ(req[0]), .MOD1_ACK(ack[0]), .MOD2_REQ(req[1]),
      .MOD2_ACK(ack[1]), .CPU_BUS_BUSY(CPU_BUS_BUSY), .CPU_HOLD(CPU_HOLD),
      .RAM_REQ(RAM_REQ), .RAM_RDATA(RAM_RDATA));
   for (genvar g = 0; g < 2; g++) begin : mod_g
      serial_module_model serial_module_model_inst (.CLK_SYS(CLK_SYS), .RST(RST),
         .start(go[g]), .stall(st[g]), .data(dat[g]), .ack(ack[g]), .req(req[g]));
   end
   // ram answers from the live address or the one latched last
   assign RAM_RDATA = ((RAM_REQ.req === 1'b1) ? RAM_REQ.addr[7:0] : la[7:0]) ^ 8'h5a;
   initial begin
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   // ****************************************
   // reference model and timeout
   // ****************************************
   always @(posedge CLK_SYS) begin
      cyc++;
      CPU_BUS_BUSY <= (CPU_HOLD !== 1'b1) && 1'($urandom);
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   // outputs are looked at mid-cycle, where they have settled after the launching edge
   always @(negedge CLK_SYS) begin
      for (int c = 0; c < 2; c++) begin
         if (ack[c].ack === 1'b1) begin
            e = 16'(base[c] + prog[c]);
            `CHK({la, lw, ack[c].rdata, prog[c] < tot[c]}, {e, dat[c][7], e[7:0] ^ 8'h5a, 1'b1})
            prog[c]++;
            nack[c]++;
            ord.push_back(c);
         end
      end
      if (RAM_REQ.req === 1'b1) begin
         la <= RAM_REQ.addr;
         lw <= RAM_REQ.we;
      end
   end
   // ****************************************
   // bus and module tasks, all entered just after a rising edge
   // ****************************************
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      S_AWADDR <= {i, 2'b00};
      S_WDATA <= {24'h0, d};
      S_AWVALID <= 1'b1;
      S_WVALID <= 1'b1;
      S_BREADY <= 1'b1;
      fork
         begin
            do @(negedge CLK_SYS); while (S_AWREADY !== 1'b1);
            @(posedge CLK_SYS);
            S_AWVALID <= 1'b0;
         end
         begin
            do @(negedge CLK_SYS); while (S_WREADY !== 1'b1);
            @(posedge CLK_SYS);
            S_WVALID <= 1'b0;
         end
      join
      do @(negedge CLK_SYS); while (S_BVALID !== 1'b1);
      brsp = S_BRESP;
      // bready stays up between calls so the next call never assigns it twice in one step
      @(posedge CLK_SYS);
   endtask
   task automatic rd(input logic [15:0] i, input logic [31:0] x, input logic [1:0] r);
      S_ARADDR <= {i, 2'b00};
      S_ARVALID <= 1'b1;
      S_RREADY <= 1'b1;
      do @(negedge CLK_SYS); while (S_ARREADY !== 1'b1);
      @(posedge CLK_SYS);
      S_ARVALID <= 1'b0;
      do @(negedge CLK_SYS); while (S_RVALID !== 1'b1);
      `CHK({S_RRESP, S_RDATA}, {r, x})
      @(posedge CLK_SYS);
   endtask
   task automatic cfg(input int c, input logic [7:0] bh, input logic [7:0] bl, input logic [7:0] ct);
      base[c] = {bh & 8'h1f, bl & 8'hf0};
      tot[c] = {bl[3:0], ct} + 2;
      prog[c] = 0;
      wr(c ? IDX_CHAN2_BASE_HIGH : IDX_CHAN1_BASE_HIGH, bh);
      wr(c ? IDX_CHAN2_BASE_LOW : IDX_CHAN1_BASE_LOW, bl);
      wr(c ? IDX_CHAN2_COUNT_LOW : IDX_CHAN1_COUNT_LOW, ct);
   endtask
   task automatic fire(input logic [1:0] m, input logic s);
      for (int c = 0; c < 2; c++) begin
         if (m[c]) begin
            dat[c] <= 8'($urandom);
            st[c] <= s;
            go[c] <= 1'b1;
         end
      end
      @(posedge CLK_SYS);
      go <= '{1'b0, 1'b0};
   endtask
   task automatic waitack(input int c, input int k);
      while (nack[c] < k) @(negedge CLK_SYS);
      @(posedge CLK_SYS);
   endtask
   task automatic xfer(input int c, input logic s);
      int k;
      k = nack[c] + 1;
      fire(2'(1 << c), s);
      waitack(c, k);
   endtask
   task automatic quiet(input int c, input int k);
      repeat (12) @(negedge CLK_SYS);
      `CHK(nack[c], k)
      @(posedge CLK_SYS);
   endtask
   task automatic complete_run();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h8ddba8bd));
      repeat (5) @(posedge CLK_SYS);
      RST <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rd(IDX_CHAN1_BASE_LOW + 16'(i < 8 ? i : i + 22), 32'h0, RESP_OKAY);
      end
      rd(16'h7ff0, 32'h0, RESP_SLVERR);
      wr(16'h7ff0, 8'h55);
      `CHK(brsp, RESP_SLVERR)
      cfg(0, 8'($urandom), {4'($urandom), 4'h0}, 8'h01);
      rd(IDX_CHAN1_BASE_HIGH, 32'(base[0] >> 8), RESP_OKAY);
      repeat (3) xfer(0, 1'b0);
      wr(IDX_CHAN1_PROGRESS, 8'h00);
      rd(IDX_CHAN1_PROGRESS, 32'd3, RESP_OKAY);
      n = nack[0];
      fire(2'b01, 1'b0);
      quiet(0, n);
      cfg(0, 8'(base[0] >> 8), 8'(base[0]), 8'h01);
      waitack(0, n + 1);
      cfg(1, 8'($urandom), {4'($urandom), 4'h1}, 8'h00);
      for (int b = 2; b < 6; b++) begin
         wr(IDX_SERVICE_DISABLE, 8'(1 << b));
         rd(IDX_SERVICE_DISABLE, 32'(1 << b), RESP_OKAY);
         n = nack[b / 4];
         fire(2'(1 << (b / 4)), 1'(b % 2));
         quiet(b / 4, n);
         wr(IDX_SERVICE_DISABLE, 8'h00);
         waitack(b / 4, n + 1);
      end
      cfg(0, 8'(base[0] >> 8), 8'(base[0]), 8'hff);
      ord.delete();
      n = nack[1];
      fire(2'b11, 1'b0);
      waitack(1, n + 1);
      `CHK(ord[0], 0)
      repeat (40) xfer($urandom % 2, 1'($urandom));
      while (prog[1] < tot[1]) xfer(1, 1'b1);
      n = nack[1];
      fire(2'b10, 1'b1);
      quiet(1, n);
      complete_run();
   end
endmodule
bind bus_steal_xfer bus_steal_xfer_props bus_steal_xfer_props_inst (
   .CLK_SYS(CLK_SYS), .RST(RST), .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY),
   .S_RVALID(S_RVALID), .MOD1_REQ(MOD1_REQ), .MOD1_ACK(MOD1_ACK), .MOD2_REQ(MOD2_REQ),
   .MOD2_ACK(MOD2_ACK), .CPU_BUS_BUSY(CPU_BUS_BUSY), .CPU_HOLD(CPU_HOLD), .RAM_REQ(RAM_REQ));
